// ---- hdl/pslk_top.sv ----
// pslk_top: profile select, data assembler timing and pll lock control.
// assumes pclk is the system core clock; apb slave; inputs synchronous.
//
// Overview of operation
// [R01] quad mode stage delays: 4N, 12N, 72N, 5N+9, 7, 7, 6 cycles.
// [R02] interp mode: demux 8N, modulator adds nothing, others unchanged.
// [R03] N is 1 when bypassed else 2..63; multiplier 1 or 4..20.
// [R04] tone hop under 30 cycles with sinc and scaler, 24 without sinc.
// [R05] quad mode: data clock is core/2N, sampling clock core/4N.
// [R06] samples leave data assembler three data clock cycles after entry.
// [R07] burst on slow rising edge samples half cycle later, falling one.
// [R08] two select pins pick profile 0..3, high pin is msb.
// [R09] each profile holds tuning word, invert, icic bypass, cic rate, scale.
// [R10] scale factor gives gain 0 to 1.9921875, msb weight one.
// [R11] cic rate 1x..63x or bypass, taken from active profile.
// [R12] selects sampled on data clock, or core clock in single tone.
// [R13] zero tuning word forces phase accumulator to zero.
// [R14] multiplier is a 5-bit field of control register 00h.
// [R15] value 01h bypasses multiplier and shuts pll down.
// [R16] values 04h..14h multiply reference; output limit 200 MHz.
// [R17] host allows about 1 ms for lock after changing multiplier.
// [R18] active-high lock indicator output when pll locked.
// [R19] lock control 0 and unlocked: hold datapath, clock low, ignore gate.
// [R20] rising lock releases all hold conditions.
// [R21] lock control 1 applies no holds; defaults to 1.
// [R22] after unlock with control 0, run full datapath clear on lock.
// [R23] other multiplier values are treated as bypass.
// [R24] all profile parameters switch together on one sampling edge.
`timescale 1ns/1ps
`default_nettype none
module pslk_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire logic profile_sel_low,
  input wire logic profile_sel_high,
  input wire logic transmit_gate,
  input wire logic [13:0] tx_data,
  // pll status from analog macro
  input wire logic pll_locked_raw,
  // pins and datapath controls
  output logic parallel_data_clock,
  output logic pll_lock_ind,
  output logic pll_enable,
  output logic [4:0] pll_mult,
  output logic sample_clk,
  output logic sample_strobe,
  output logic [13:0] chain_data,
  output logic tx_active,
  output var pslk_pkg::pslk_prof_t act_prof,
  output var pslk_pkg::pslk_hold_t hold,
  output logic [31:0] phase_acc
);
  import pslk_pkg::*;

  // =====================================================
  // functions
  function automatic logic [5:0] eff_n(input logic [5:0] r);
    eff_n = (r <= PSLK_CIC_BYP) ? 6'h01 : r;
  endfunction
  function automatic logic mult_ok(input logic [4:0] m);
    mult_ok = (m >= PSLK_MULT_MIN) && (m <= PSLK_MULT_MAX);
  endfunction

  // =====================================================
  // registers
  logic [31:0] ctrl_q;
  logic [31:0] ftw_q [4];
  logic [15:0] pw1_q [4];
  logic [1:0] psel_q;
  logic lock_q, lock_d1_q, clear_q;
  logic [6:0] div_q;
  logic parallel_data_clock_q, sclk_q, s_rise_q;
  logic [13:0] asm_q [PSLK_ASM_STAGES];
  logic burst_q, gate_q, late_q;
  logic [16:0] lat_q;
  logic [5:0] hop_q;

  // =====================================================
  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [7:0] prof_off = paddr - PSLK_PROF_BASE;
  wire is_prof = (paddr >= PSLK_PROF_BASE) &&
                 (paddr < PSLK_PROF_BASE + 8'h20) && (paddr[1:0] == 2'b00);
  wire [1:0] pidx = prof_off[4:3];
  wire pword = prof_off[2];
  wire hit = is_prof || paddr == PSLK_CTRL_OFS ||
             paddr == PSLK_STAT_OFS || paddr == PSLK_LAT_OFS ||
             paddr == PSLK_HOP_OFS;
  wire [4:0] mult_f = ctrl_q[PSLK_MULT_LSB +: 5];
  wire lock_ctl = ctrl_q[PSLK_LOCKCTL_BIT];
  wire [1:0] mode = ctrl_q[PSLK_MODE_LSB +: 2];
  wire tone = mode == PSLK_MODE_TONE;
  wire interp = mode == PSLK_MODE_INTERP;

  // =====================================================
  // pll: 01h or illegal -> bypass with pll off   see [R14] see [R23]
  wire mult_on = mult_ok(mult_f);                 // see [R16]
  wire [4:0] mult_d = mult_on ? mult_f : PSLK_MULT_BYP; // see [R15] see [R03]
  // bypassed reference is trivially locked
  wire lock_d = mult_on ? pll_locked_raw : 1'b1;  // see [R18]
  // holds only when lock control bit is 0   see [R19] see [R21]
  wire holding = !lock_ctl && !lock_q;
  wire lock_rise = lock_q && !lock_d1_q;          // see [R20]

  // =====================================================
  // profile selection   see [R08]
  wire [1:0] sel_pins = {profile_sel_high, profile_sel_low};
  // quad/interp sample one core cycle after data clock falls (on its rise when N is 1), tone on every core edge
  wire sel_take = tone || (div_q == 7'h00 && !parallel_data_clock_q); // see [R12]
  wire pslk_prof_t prof_d = '{ftw: ftw_q[psel_q],       // see [R09]
      spec_inv: pw1_q[psel_q][PSLK_SPINV_BIT] && !tone && !interp,
      icic_byp: pw1_q[psel_q][PSLK_ICICBYP_BIT],
      cic_rate: pw1_q[psel_q][PSLK_CIC_LSB +: 6],       // see [R11]
      scale: pw1_q[psel_q][PSLK_SCALE_LSB +: 8]};       // see [R10]
  wire [5:0] n_act = eff_n(act_prof.cic_rate);          // see [R03]

  // =====================================================
  // clock division: data clock = core/2N, sampling = core/4N  see [R05]
  wire [6:0] half_n = {1'b0, n_act} - 7'h01;
  wire div_wrap = div_q >= half_n;
  wire pd_rise = div_wrap && !parallel_data_clock_q && !holding;

  // =====================================================
  // latency figures   see [R01] see [R02]
  wire [16:0] nn = {11'h000, n_act};
  wire [16:0] lat_d = nn * {11'h000, interp ? PSLK_DEMUX_ID : PSLK_DEMUX_QM}
      + (act_prof.icic_byp ? 17'h0 : nn * {11'h000, PSLK_ICIC_K})
      + nn * {10'h000, PSLK_FIXI_K} + nn * {11'h000, PSLK_PROGI_K}
      + {11'h000, PSLK_PROGI_C}
      + (interp ? 17'h0 : {11'h000, PSLK_MOD_LAT})
      + (ctrl_q[PSLK_ISINC_BIT] ? {11'h000, PSLK_ISINC_LAT} : 17'h0)
      + (ctrl_q[PSLK_SCALER_BIT] ? {11'h000, PSLK_SCALER_LAT} : 17'h0);
  // tone hop budget   see [R04]
  wire [5:0] hop_d = ctrl_q[PSLK_ISINC_BIT] ? PSLK_HOP_FULL : PSLK_HOP_NOSINC;

  // =====================================================
  // read mux
  wire [31:0] stat_w = {24'h0, psel_q, 2'b00, clear_q, holding, burst_q,
                        lock_q};
  wire [31:0] rd_w = paddr == PSLK_CTRL_OFS ? ctrl_q :
      paddr == PSLK_STAT_OFS ? stat_w :
      paddr == PSLK_LAT_OFS ? {15'h0, lat_q} :
      paddr == PSLK_HOP_OFS ? {26'h0, hop_q} :
      !is_prof ? 32'h0 :
      pword ? {16'h0, pw1_q[pidx]} : ftw_q[pidx];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= (psel && !penable && !pwrite) ? rd_w : prdata;
    end
  end

  // =====================================================
  // register writes take effect on the access cycle with pready high
  wire wr_ok = wr && pready && hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= PSLK_CTRL_RST;                     // see [R21]
    end else if (wr_ok && paddr == PSLK_CTRL_OFS) begin
      ctrl_q <= pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        ftw_q[i] <= 32'h0;
        pw1_q[i] <= PSLK_PROF1_RST;
      end
    end else if (wr_ok && is_prof) begin
      if (pword) begin
        pw1_q[pidx] <= pwdata[15:0];
      end else begin
        ftw_q[pidx] <= pwdata;
      end
    end
  end

  // =====================================================
  // lock tracking and post-lock clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      lock_d1_q <= 1'b0;
      clear_q <= 1'b1;
    end else begin
      lock_q <= lock_d;
      lock_d1_q <= lock_q;
      // clear routine: flush assembler until the first data clock rise after lock
      if (!lock_ctl && lock_rise) begin
        clear_q <= 1'b1;                           // see [R22]
      end else if (pd_rise) begin
        clear_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // profile register, all fields in one edge   see [R24]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel_q <= 2'b00;
      act_prof <= '0;
    end else if (sel_take) begin
      psel_q <= sel_pins;
      act_prof <= prof_d;
    end
  end

  // =====================================================
  // dividers; data clock forced low while held   see [R19]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h00;
      parallel_data_clock_q <= 1'b0;
      sclk_q <= 1'b0;
      s_rise_q <= 1'b0;
    end else if (holding) begin
      div_q <= 7'h00;
      parallel_data_clock_q <= 1'b0;
      sclk_q <= 1'b0;
      s_rise_q <= 1'b0;
    end else begin
      div_q <= div_wrap ? 7'h00 : div_q + 7'h01;
      parallel_data_clock_q <= div_wrap ? !parallel_data_clock_q : parallel_data_clock_q;
      // slow clock toggles on data clock rising edges   see [R05]
      sclk_q <= pd_rise ? !sclk_q : sclk_q;
      s_rise_q <= pd_rise && !sclk_q;
    end
  end

  // =====================================================
  // data assembler: three data clock stages   see [R06]
  wire zero_in = holding || clear_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PSLK_ASM_STAGES; i++) begin
        asm_q[i] <= 14'h0;
      end
    end else if (zero_in) begin
      for (int i = 0; i < PSLK_ASM_STAGES; i++) begin
        asm_q[i] <= 14'h0;                         // see [R19]
      end
    end else if (pd_rise) begin
      asm_q[0] <= (burst_q || gate_q) ? tx_data : 14'h0;
      for (int i = 1; i < PSLK_ASM_STAGES; i++) begin
        asm_q[i] <= asm_q[i-1];
      end
    end
  end

  // =====================================================
  // burst start phase; gate ignored while held   see [R07] see [R19]
  wire gate_in = transmit_gate && !holding;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
      burst_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      if (pd_rise) begin
        gate_q <= gate_in;
        // start on a falling slow edge samples one full slow cycle on
        if (gate_in && !gate_q) begin
          late_q <= sclk_q;
        end
        burst_q <= gate_q;
      end
      if (holding) begin
        burst_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // outputs and dds phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_data_clock <= 1'b0;
      pll_lock_ind <= 1'b0;
      pll_enable <= 1'b0;
      pll_mult <= PSLK_MULT_BYP;
      sample_clk <= 1'b0;
      sample_strobe <= 1'b0;
      chain_data <= 14'h0;
      tx_active <= 1'b0;
      hold <= '1;
      phase_acc <= 32'h0;
      lat_q <= 17'h0;
      hop_q <= 6'h0;
    end else begin
      parallel_data_clock <= parallel_data_clock_q;
      pll_lock_ind <= lock_q;                      // see [R18]
      pll_enable <= mult_on;                       // see [R15]
      pll_mult <= mult_d;
      sample_clk <= sclk_q;
      // sampling on slow clock rising edge, none while held or clearing
      sample_strobe <= s_rise_q && !zero_in;
      // i/q path reads zero while held or clearing   see [R19]
      chain_data <= zero_in ? 14'h0 :
          s_rise_q ? asm_q[PSLK_ASM_STAGES-1] : chain_data;
      tx_active <= burst_q;
      hold <= '{dds_clear: holding, iq_zero: zero_in,
                cic_clear: zero_in, gate_ignored: holding};
      // zero tuning word presets phase to zero   see [R13]
      phase_acc <= (holding || act_prof.ftw == 32'h0) ? 32'h0
                 : phase_acc + act_prof.ftw;
      // late start costs one whole data clock, 2N core cycles
      lat_q <= lat_d + (late_q ? {10'h0, n_act, 1'b0} : 17'h0); // see [R07]
      hop_q <= hop_d;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pslk_pkg.sv ----
// pslk_pkg: constants, register map and carrier types for the profile
// select and pll lock control block; shared by design and bench.
package pslk_pkg;
  // =====================================================
  // register byte offsets (apb, one word each)
  localparam logic [7:0] PSLK_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSLK_STAT_OFS = 8'h04;
  localparam logic [7:0] PSLK_PROF_BASE = 8'h10;
  localparam logic [7:0] PSLK_PROF_STRIDE = 8'h08;
  localparam logic [7:0] PSLK_LAT_OFS = 8'h30;
  localparam logic [7:0] PSLK_HOP_OFS = 8'h34;
  // =====================================================
  // control register fields
  localparam int PSLK_MULT_LSB = 0;
  localparam int PSLK_LOCKCTL_BIT = 5;
  localparam int PSLK_MODE_LSB = 8;
  localparam int PSLK_ISINC_BIT = 10;
  localparam int PSLK_SCALER_BIT = 11;
  localparam logic [4:0] PSLK_MULT_BYP = 5'h01;
  localparam logic [4:0] PSLK_MULT_MIN = 5'h04;
  localparam logic [4:0] PSLK_MULT_MAX = 5'h14;
  localparam logic [31:0] PSLK_CTRL_RST = 32'h0000_0021;
  // profile word 1 fields
  localparam int PSLK_CIC_LSB = 0;
  localparam int PSLK_SPINV_BIT = 6;
  localparam int PSLK_ICICBYP_BIT = 7;
  localparam int PSLK_SCALE_LSB = 8;
  localparam logic [5:0] PSLK_CIC_BYP = 6'h01;
  localparam logic [15:0] PSLK_PROF1_RST = 16'hb508;
  // =====================================================
  // latency figures, system clock cycles; assembler depth in data clock stages
  localparam logic [5:0] PSLK_DEMUX_QM = 6'h04;
  localparam logic [5:0] PSLK_DEMUX_ID = 6'h08;
  localparam logic [5:0] PSLK_ICIC_K = 6'h0c;
  localparam logic [6:0] PSLK_FIXI_K = 7'h48;
  localparam logic [5:0] PSLK_PROGI_K = 6'h05;
  localparam logic [5:0] PSLK_PROGI_C = 6'h09;
  localparam logic [5:0] PSLK_MOD_LAT = 6'h07;
  localparam logic [5:0] PSLK_ISINC_LAT = 6'h07;
  localparam logic [5:0] PSLK_SCALER_LAT = 6'h06;
  localparam logic [5:0] PSLK_HOP_FULL = 6'h1d;
  localparam logic [5:0] PSLK_HOP_NOSINC = 6'h17;
  localparam int PSLK_ASM_STAGES = 3;
  // =====================================================
  typedef enum logic [1:0] {
    PSLK_MODE_QUAD, PSLK_MODE_TONE, PSLK_MODE_INTERP, PSLK_MODE_RSVD
  } pslk_mode_t;
  typedef struct packed {
    logic [31:0] ftw;
    logic spec_inv;
    logic icic_byp;
    logic [5:0] cic_rate;
    logic [7:0] scale;
  } pslk_prof_t;
  typedef struct packed {
    logic dds_clear;
    logic iq_zero;
    logic cic_clear;
    logic gate_ignored;
  } pslk_hold_t;
endpackage

// ---- test/pslk_host_model.sv ----
// pslk_host_model: far-side host driving profile pins, gate and samples.
// assumes bench requests are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pslk_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic parallel_data_clock,
  // bench requests
  input wire logic [1:0] prof_req,
  input wire logic gate_req,
  // host pins
  output logic profile_sel_low,
  output logic profile_sel_high,
  output logic transmit_gate,
  output logic [13:0] tx_data
);
  logic pd_q;
  // =====================================================
  // pins change just after a clock edge, data after a data clock rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_q <= 1'b0;
      profile_sel_low <= 1'b0;
      profile_sel_high <= 1'b0;
      transmit_gate <= 1'b0;
      tx_data <= 14'h0000;
    end else begin
      pd_q <= parallel_data_clock;
      profile_sel_high <= prof_req[1];
      profile_sel_low <= prof_req[0];
      transmit_gate <= gate_req;
      if (parallel_data_clock && !pd_q) begin
        // idle bus shows a changing pattern, never a stale value
        tx_data <= gate_req ? tx_data + 14'h0001 : ~tx_data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/pslk_top_properties.sv ----
// pslk_top_properties: concurrent checks on the pslk_top ports.
// assumes one pclk domain; bound into every pslk_top.
`timescale 1ns/1ps
`default_nettype none
module pslk_top_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pll and datapath
  input wire logic pll_locked_raw,
  input wire logic pll_lock_ind,
  input wire logic pll_enable,
  input wire logic [4:0] pll_mult,
  input wire logic parallel_data_clock,
  input wire logic sample_strobe,
  input wire logic tx_active,
  input wire logic [31:0] phase_acc,
  input wire pslk_pkg::pslk_hold_t hold
);
  import pslk_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================================
  a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_mult_legal: assert property (
    pll_mult == 5'h01 || (pll_mult >= 5'h04 && pll_mult <= 5'h14))
    else $error("illegal multiplier driven");
  a_enable_mult: assert property (
    pll_enable == (pll_mult != 5'h01))
    else $error("pll enable disagrees with multiplier");
  a_bypass_lock: assert property (
    !pll_enable [*3] |-> pll_lock_ind)
    else $error("lock low while bypassed");
  a_lock_follow: assert property (
    (pll_enable && !pll_locked_raw) [*3] |-> !pll_lock_ind)
    else $error("lock high without pll lock");
  a_held_clock: assert property (
    hold.gate_ignored [*2] |-> !parallel_data_clock)
    else $error("data clock runs while held");
  a_held_phase: assert property (
    hold.dds_clear [*2] |-> phase_acc == 0)
    else $error("phase moves while held");
  a_held_gate: assert property (
    hold.gate_ignored [*2] |-> !$rose(tx_active))
    else $error("burst starts while held");
  a_lock_release: assert property (
    $rose(pll_lock_ind) |-> ##[0:2] !hold.gate_ignored)
    else $error("hold kept after lock");
  a_strobe_pulse: assert property (
    sample_strobe |=> !sample_strobe)
    else $error("sample strobe too long");
  // =====================================================
  c_lock: cover property ($rose(pll_lock_ind));
  c_refused: cover property (pslverr);
  c_sample: cover property (sample_strobe);
  c_release: cover property ($fell(hold.gate_ignored));
endmodule
bind pslk_top pslk_top_props i_pslk_top_props (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .pll_locked_raw, .pll_lock_ind, .pll_enable,
  .pll_mult, .parallel_data_clock, .sample_strobe, .tx_active, .phase_acc,
  .hold);
`default_nettype wire

// ---- test/pslk_top_tb.sv ----
// pslk_top_tb: apb sequences with expected values for pslk_top.
// assumes pslk_host_model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module pslk_top_tb;
  import pslk_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pll_locked_raw, gate_req, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0] prof_req;
  logic [4:0] mv [8] = '{5'h02, 5'h03, 5'h04, 5'h14, 5'h15, 5'h1f, 5'h00,
    5'h01};
  wire logic pready, pslverr, profile_sel_low, profile_sel_high;
  wire logic transmit_gate, parallel_data_clock, pll_lock_ind, pll_enable;
  wire logic sample_clk, sample_strobe, tx_active;
  wire logic [4:0] pll_mult;
  wire logic [13:0] tx_data, chain_data;
  wire logic [31:0] prdata, phase_acc;
  wire pslk_prof_t act_prof;
  wire pslk_hold_t hold;
  int n_errors, compares, cyc, a, b;
  logic [4:0] e;
  logic [31:0] f;
  logic [7:0] s;
  logic [5:0] c;
  logic [13:0] v;
  // =====================================================
  pslk_top i_pslk_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .profile_sel_low,
    .profile_sel_high, .transmit_gate, .tx_data, .pll_locked_raw,
    .parallel_data_clock, .pll_lock_ind, .pll_enable, .pll_mult,
    .sample_clk, .sample_strobe, .chain_data, .tx_active, .act_prof, .hold,
    .phase_acc);
  pslk_host_model i_pslk_host_model (.pclk, .presetn, .parallel_data_clock,
    .prof_req, .gate_req, .profile_sel_low, .profile_sel_high,
    .transmit_gate, .tx_data);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // =====================================================
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // rises of data clock and slow clock in a 252 cycle window
  task rises(output int na, nb);
    logic pa, pb;
    na = 0;
    nb = 0;
    pa = parallel_data_clock;
    pb = sample_clk;
    repeat (252) begin
      @(posedge pclk);
      if (parallel_data_clock && !pa) na++;
      if (sample_clk && !pb) nb++;
      pa = parallel_data_clock;
      pb = sample_clk;
    end
  endtask
  function logic [31:0] cw(input logic [4:0] m, input logic lc,
    input logic [1:0] md, input logic is, sc);
    return {20'h0, sc, is, md, 2'b00, lc, m};
  endfunction
  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test;
    end
  end
  // =====================================================
  initial begin
    {presetn, psel, penable, pwrite, pll_locked_raw, gate_req} = '0;
    {paddr, pwdata, prof_req} = '0;
    wt(4);
    presetn <= 1'b1;
    wt(2);
    apb(0, PSLK_CTRL_OFS, 0);
    chk("ctrl", rd, 32'h0000_0021);
    apb(0, PSLK_PROF_BASE + 8'h04, 0);
    chk("prof_word1", rd, 32'h0000_b508);
    chk("lock_bypass", pll_lock_ind, 1);
    for (int i = 0; i < 8; i++) begin
      apb(1, PSLK_CTRL_OFS, cw(mv[i], 1, 0, 0, 0));
      wt(2);
      e = (mv[i] >= 5'h04 && mv[i] <= 5'h14) ? mv[i] : 5'h01;
      chk("mult", pll_mult, e);
      chk("pll_en", pll_enable, e != 5'h01);
    end
    apb(0, 8'hfc, 0);
    chk("unmapped_err", err, 1);
    chk("unmapped_rd", rd, 0);
    for (int i = 0; i < 2; i++) begin
      apb(1, PSLK_CTRL_OFS, cw(1, 1, PSLK_MODE_TONE, !i, 1));
      apb(0, PSLK_HOP_OFS, 0);
      chk("hop", rd, i ? 32'd23 : 32'd29);
    end
    apb(1, PSLK_CTRL_OFS, cw(1, 1, PSLK_MODE_QUAD, 0, 0));
    for (int p = 0; p < 4; p++) begin
      f = 32'h0100_0000 * p;
      s = 8'h80 + p;
      c = (p == 3) ? 6'h3f : 6'h01;
      apb(1, 8'(PSLK_PROF_BASE + 8 * p), f);
      apb(1, 8'(PSLK_PROF_BASE + 8 * p + 4), {16'h0, s, p[0], p[1], c});
    end
    for (int p = 0; p < 4; p++) begin
      f = 32'h0100_0000 * p;
      s = 8'h80 + p;
      c = (p == 3) ? 6'h3f : 6'h01;
      prof_req <= p;
      repeat (20) begin
        @(posedge pclk);
        chk("no_mix", act_prof.ftw == f, act_prof.scale == s);
      end
      chk("ftw", act_prof.ftw, f);
      chk("fields", {act_prof.spec_inv,
        act_prof.icic_byp, act_prof.cic_rate, act_prof.scale},
        {p[1], p[0], c, s});
      apb(0, PSLK_STAT_OFS, 0);
      chk("stat_sel", rd[7:6], p);
      rises(a, b);
      chk("parallel_data_clock_rises", a, p == 3 ? 2 : 126);
      chk("slow_rises", b, p == 3 ? 1 : 63);
    end
    // profile 3 active: N = 63, inverse cic bypassed
    // quad 4N+72N+5N+9+7; interp with sinc and scaler 8N+72N+5N+9+7+6
    for (int i = 0; i < 2; i++) begin
      apb(1, PSLK_CTRL_OFS, cw(1, 1, i ? PSLK_MODE_INTERP : PSLK_MODE_QUAD,
        i[0], i[0]));
      apb(0, PSLK_LAT_OFS, 0);
      chk("latency", rd, i ? 32'd5377 : 32'd5119);
    end
    apb(1, PSLK_CTRL_OFS, cw(1, 1, PSLK_MODE_TONE, 0, 0));
    prof_req <= 2'd0;
    wt(20);
    chk("phase_zero", phase_acc, 0);
    prof_req <= 2'd1;
    wt(20);
    chk("phase_runs", phase_acc != 0, 1);
    apb(1, PSLK_CTRL_OFS, cw(4, 0, PSLK_MODE_QUAD, 0, 0));
    gate_req <= 1'b1;
    wt(10000);
    chk("unlocked", pll_lock_ind, 0);
    chk("hold_all", hold, 4'hf);
    rises(a, b);
    chk("parallel_data_clock_held", a, 0);
    chk("gate_ignored", tx_active, 0);
    pll_locked_raw <= 1'b1;
    wt(20);
    chk("locked", pll_lock_ind, 1);
    chk("hold_free", hold, 0);
    chk("burst", tx_active, 1);
    rises(a, b);
    chk("parallel_data_clock_back", a, 126);
    // host counts once per data clock, chain samples every second one
    do @(posedge pclk); while (sample_strobe !== 1'b1);
    v = chain_data;
    do @(posedge pclk); while (sample_strobe !== 1'b1);
    chk("chain_step", 14'(chain_data - v), 14'h0002);
    pll_locked_raw <= 1'b0;
    wt(10);
    chk("relock_hold", hold, 4'hf);
    chk("chain_zero", chain_data, 0);
    apb(1, PSLK_CTRL_OFS, cw(4, 1, PSLK_MODE_QUAD, 0, 0));
    wt(10);
    chk("lock_drop", pll_lock_ind, 0);
    chk("no_hold", hold, 0);
    rises(a, b);
    chk("parallel_data_clock_free", a, 126);
    end_of_test;
  end
endmodule
`default_nettype wire
